// ===== include/pecnt_cfg.svh
// Register offsets, widths and interrupt layout of the PHY event counters.
`ifndef PECNT_CFG_SVH
`define PECNT_CFG_SVH
`define PECNT_NUM_CNT 7
`define PECNT_CNT_W 16
`define PECNT_CNT_RESET 16'h0000
`define PECNT_IDX_FALSE_CARRIER 8'h13
`define PECNT_IDX_DISCONNECT 8'h14
`define PECNT_IDX_RX_ERR_FRAME 8'h15
`define PECNT_IDX_SYMBOL_ERR 8'h16
`define PECNT_IDX_FAST_EOF 8'h17
`define PECNT_IDX_SLOW_EOF 8'h18
`define PECNT_IDX_JABBER 8'h19
`define PECNT_IDX_IRQ_STATUS 8'h1C
`define PECNT_IDX_IRQ_CLEAR 8'h1D
`define PECNT_IDX_IRQ_ENABLE 8'h1E
`define PECNT_IDX_W 8
`define PECNT_IRQ_RESET 7'h00
`endif

// ===== include/pecnt_pkg.sv
// Types shared by the PHY event counter block.
package pecnt_pkg;
  typedef struct packed {
    logic tx_jabber;
    logic slow_eof_error;
    logic fast_early_eof;
    logic symbol_error;
    logic rx_error_frame;
    logic repeater_disconnect;
    logic false_carrier;
  } pecnt_events_s;
  typedef struct packed {
    logic [1:0] htrans;
    logic [31:0] haddr;
    logic hwrite;
    logic [2:0] hsize;
  } pecnt_ahb_addr_s;
  typedef enum logic [1:0] {
    PECNT_DP_IDLE = 2'b00,
    PECNT_DP_READ = 2'b01,
    PECNT_DP_WRITE = 2'b10
  } pecnt_dphase_e;
endpackage

// ===== rtl/pecnt_sat_counter.sv
// One saturating, clear-on-read 16-bit event counter.
`timescale 1ns/100ps
module pecnt_sat_counter #(
  parameter int WIDTH = 16
) (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Event and clearing read.
  input wire logic i_event,
  input wire logic i_clear,
  // Count.
  output logic [WIDTH-1:0] o_count
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic full;

  assign full = &count;
  assign o_count = count;

  // A clearing read that meets an event leaves the count at one.
  always_comb begin
    next_count = count;
    if (i_clear) begin
      next_count = {{(WIDTH-1){1'b0}}, i_event};
    end else if (i_event && !full) begin
      next_count = count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
endmodule

// ===== rtl/pecnt_top.sv
// PHY error event counters with an AHB-Lite register slave.
//
// What this block does
// - False-carrier counter, 16 bits, counts non-JK frames.
// - False-carrier saturates; read returns value then clears.
// - Disconnect counter counts repeater-mode non-JK frames.
// - Disconnect saturates; read returns value then clears.
// - Error-frame counter counts symbol or early-EOF frames.
// - Error-frame saturates; read returns value then clears.
// - Symbol-error counter counts each symbol error.
// - Symbol-error saturates; read returns value then clears.
// - Fast early-EOF counter counts each premature end.
// - Fast early-EOF saturates; read returns then clears.
// - Slow EOF-error counter counts each 10 Mbps error.
// - Slow EOF-error saturates; read returns then clears.
// - Jabber counter counts each transmit jabber detection.
// - Jabber saturates; read returns value then clears.
`timescale 1ns/100ps
`include "pecnt_cfg.svh"
module pecnt_top #(
  parameter int CNT_W = `PECNT_CNT_W
) (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Event strobes from the receive and transmit paths, one cycle each.
  input wire pecnt_pkg::pecnt_events_s i_events,
  // AHB-Lite slave.
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic i_hready,
  input wire logic [31:0] i_hwdata,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // Interrupt.
  output logic o_irq
);
  localparam int N = `PECNT_NUM_CNT;

  // Counters sit at word indices 0x13 to 0x19 in event order, and the
  // interrupt status, clear and enable words at 0x1C, 0x1D and 0x1E.
  // No access ever waits and none is refused with an error, so a host
  // may issue transfers back to back.

  pecnt_pkg::pecnt_ahb_addr_s req;
  logic take;
  pecnt_pkg::pecnt_dphase_e dphase;
  pecnt_pkg::pecnt_dphase_e next_dphase;
  logic [`PECNT_IDX_W-1:0] dindex;
  logic [`PECNT_IDX_W-1:0] next_dindex;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [N-1:0] irq_status;
  logic [N-1:0] next_irq_status;
  logic [N-1:0] irq_enable;
  logic [N-1:0] next_irq_enable;
  logic irq;
  logic next_irq;
  logic [N-1:0] ev;
  logic [N-1:0] clr;
  logic [N-1:0] sat;
  logic [CNT_W-1:0] count [N];
  logic [`PECNT_IDX_W-1:0] aindex;
  logic [31:0] rd_mux;
  logic in_range;
  logic rd_take;
  logic hreadyout;
  logic next_hreadyout;
  logic hresp;
  logic next_hresp;
  logic [N-1:0] irq_clear;

  assign req.htrans = i_htrans;
  assign req.haddr = i_haddr;
  assign req.hwrite = i_hwrite;
  assign req.hsize = i_hsize;
  // Only NONSEQ and SEQ carry a transfer; IDLE and BUSY are ignored.
  assign take = i_hsel && i_hready && req.htrans[1];
  // Offsets are word indices, so the byte address is four times each.
  assign aindex = req.haddr[`PECNT_IDX_W+1:2];
  // Address bits above the index must be zero, so that no register
  // shows up again higher in the map and a stray read clears nothing.
  assign in_range = req.haddr[31:`PECNT_IDX_W+2] == '0;
  assign rd_take = take && in_range && !req.hwrite;

  // The strobes come from logic on this clock, so no synchroniser is
  // needed; every high cycle is one event.
  assign ev[0] = i_events.false_carrier;
  assign ev[1] = i_events.repeater_disconnect;
  assign ev[2] = i_events.rx_error_frame;
  assign ev[3] = i_events.symbol_error;
  assign ev[4] = i_events.fast_early_eof;
  assign ev[5] = i_events.slow_eof_error;
  assign ev[6] = i_events.tx_jabber;

  // The read data is latched in the address phase, so the clear lands
  // on the same edge and the returned value is the one before clearing.
  always_comb begin
    rd_mux = 32'h0000_0000;
    clr = '0;
    if (in_range) begin
      unique case (aindex)
        `PECNT_IDX_FALSE_CARRIER: begin
          rd_mux = {{(32-CNT_W){1'b0}}, count[0]};
          clr[0] = rd_take;
        end
        `PECNT_IDX_DISCONNECT: begin
          rd_mux = {{(32-CNT_W){1'b0}}, count[1]};
          clr[1] = rd_take;
        end
        `PECNT_IDX_RX_ERR_FRAME: begin
          rd_mux = {{(32-CNT_W){1'b0}}, count[2]};
          clr[2] = rd_take;
        end
        `PECNT_IDX_SYMBOL_ERR: begin
          rd_mux = {{(32-CNT_W){1'b0}}, count[3]};
          clr[3] = rd_take;
        end
        `PECNT_IDX_FAST_EOF: begin
          rd_mux = {{(32-CNT_W){1'b0}}, count[4]};
          clr[4] = rd_take;
        end
        `PECNT_IDX_SLOW_EOF: begin
          rd_mux = {{(32-CNT_W){1'b0}}, count[5]};
          clr[5] = rd_take;
        end
        `PECNT_IDX_JABBER: begin
          rd_mux = {{(32-CNT_W){1'b0}}, count[6]};
          clr[6] = rd_take;
        end
        `PECNT_IDX_IRQ_STATUS: begin
          rd_mux = {{(32-N){1'b0}}, irq_status};
        end
        `PECNT_IDX_IRQ_ENABLE: begin
          rd_mux = {{(32-N){1'b0}}, irq_enable};
        end
        default: begin
          rd_mux = 32'h0000_0000;
        end
      endcase
    end
  end

  // Seven copies of one counter; they differ only in the event that
  // feeds them and the read that clears them.
  // False carrier: a received frame that does not open with JK.
  // Once full it reads 0xFFFF until a read clears it, however many more.
  pecnt_sat_counter #(
    .WIDTH(CNT_W)
  ) u_false_carrier (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_event(ev[0]),
    .i_clear(clr[0]),
    .o_count(count[0])
  );

  // Repeater disconnect: a non-JK frame start seen in repeater mode.
  // The mode decision lives in the receive path; this only counts.
  pecnt_sat_counter #(
    .WIDTH(CNT_W)
  ) u_repeater_disconnect (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_event(ev[1]),
    .i_clear(clr[1]),
    .o_count(count[1])
  );

  // Receive error frame: one strobe per frame, however many errors.
  // The receive path must merge a frame's errors into that one strobe.
  pecnt_sat_counter #(
    .WIDTH(CNT_W)
  ) u_rx_error_frame (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_event(ev[2]),
    .i_clear(clr[2]),
    .o_count(count[2])
  );

  // Symbol error: one strobe per bad symbol, so one frame may add many.
  // A burst of noise can fill this counter long before the others.
  pecnt_sat_counter #(
    .WIDTH(CNT_W)
  ) u_symbol_error (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_event(ev[3]),
    .i_clear(clr[3]),
    .o_count(count[3])
  );

  // Fast early EOF: a 100 Mbps frame cut short.
  // It feeds the error-frame count as well, through the receive path.
  pecnt_sat_counter #(
    .WIDTH(CNT_W)
  ) u_fast_early_eof (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_event(ev[4]),
    .i_clear(clr[4]),
    .o_count(count[4])
  );

  // Slow EOF error: a bad frame end in 10 Mbps reception.
  // Only the 10 Mbps receive path pulses this strobe.
  pecnt_sat_counter #(
    .WIDTH(CNT_W)
  ) u_slow_eof_error (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_event(ev[5]),
    .i_clear(clr[5]),
    .o_count(count[5])
  );

  // Transmit jabber: the transmitter ran on past its allowed time.
  // This is the only counter fed from the transmit side.
  pecnt_sat_counter #(
    .WIDTH(CNT_W)
  ) u_tx_jabber (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_event(ev[6]),
    .i_clear(clr[6]),
    .o_count(count[6])
  );

  // Only an event that meets a full counter outside its clearing read
  // is dropped, and only a dropped event raises status.
  assign sat[0] = ev[0] && (&count[0]) && !clr[0];
  assign sat[1] = ev[1] && (&count[1]) && !clr[1];
  assign sat[2] = ev[2] && (&count[2]) && !clr[2];
  assign sat[3] = ev[3] && (&count[3]) && !clr[3];
  assign sat[4] = ev[4] && (&count[4]) && !clr[4];
  assign sat[5] = ev[5] && (&count[5]) && !clr[5];
  assign sat[6] = ev[6] && (&count[6]) && !clr[6];

  // Bus slave: zero wait states, always OKAY; counter writes are dropped.
  always_comb begin
    next_dphase = pecnt_pkg::PECNT_DP_IDLE;
    next_dindex = dindex;
    next_rdata = rdata;
    if (take) begin
      next_dindex = aindex;
      if (req.hwrite) begin
        if (in_range) begin
          next_dphase = pecnt_pkg::PECNT_DP_WRITE;
        end
      end else begin
        next_dphase = pecnt_pkg::PECNT_DP_READ;
        next_rdata = rd_mux;
      end
    end
  end

  // No access needs a wait state or an error, yet both answers leave
  // from flip-flops so that the bus sees no logic between edge and pin.
  always_comb begin
    next_hreadyout = 1'b1;
    next_hresp = 1'b0;
  end

  // Only the clear and enable words take write data; a write to a
  // counter lands nowhere, which is what keeps the counters read-only.
  always_comb begin
    irq_clear = '0;
    next_irq_enable = irq_enable;
    if (dphase == pecnt_pkg::PECNT_DP_WRITE) begin
      unique case (dindex)
        `PECNT_IDX_IRQ_CLEAR: begin
          irq_clear = i_hwdata[N-1:0];
        end
        `PECNT_IDX_IRQ_ENABLE: begin
          next_irq_enable = i_hwdata[N-1:0];
        end
        default: begin
          irq_clear = '0;
        end
      endcase
    end
  end

  // Status sets when a counter saturates and drops an event. Set wins
  // over a clear written in the same cycle.
  always_comb begin
    next_irq_status = (irq_status & ~irq_clear) | sat;
    next_irq = |(next_irq_status & next_irq_enable);
  end

  // Read data stands from the edge that ends the address phase until
  // the next read is taken.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dphase <= pecnt_pkg::PECNT_DP_IDLE;
      dindex <= '0;
      rdata <= 32'h0000_0000;
    end else begin
      dphase <= next_dphase;
      dindex <= next_dindex;
      rdata <= next_rdata;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= next_hreadyout;
      hresp <= next_hresp;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_enable <= `PECNT_IRQ_RESET;
    end else begin
      irq_enable <= next_irq_enable;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_status <= `PECNT_IRQ_RESET;
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq <= next_irq;
    end
  end

  assign o_hrdata = rdata;
  assign o_hreadyout = hreadyout;
  assign o_hresp = hresp;
  assign o_irq = irq;
endmodule

// ===== test/pecnt_monitor.sv
// Checker for clear-on-read counter behaviour, bound to the top module.
`timescale 1ns/100ps
module pecnt_monitor (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Watched ports.
  input wire pecnt_pkg::pecnt_events_s i_events,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic o_irq
);
  logic [6:0] rd_hit;
  always_comb begin
    for (int k = 0; k < 7; k++) begin
      rd_hit[k] = i_hsel && i_hready && i_htrans[1] && !i_hwrite
        && i_haddr == 32'(4 * (8'h13 + k));
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // A quiet gap between two reads must leave nothing to report.
  property clr(int k);
    rd_hit[k] && !i_events[k] ##1 !i_events[k] ##1 rd_hit[k]
      |=> o_hrdata == 32'h0;
  endproperty
  fc_clear_a: assert property (clr(0)) else $error("stale count");
  dc_clear_a: assert property (clr(1)) else $error("stale count");
  ef_clear_a: assert property (clr(2)) else $error("stale count");
  se_clear_a: assert property (clr(3)) else $error("stale count");
  fe_clear_a: assert property (clr(4)) else $error("stale count");
  sl_clear_a: assert property (clr(5)) else $error("stale count");
  jb_clear_a: assert property (clr(6)) else $error("stale count");
  hi_zero_a: assert property (rd_hit != 7'h00 |=>
    o_hrdata[31:16] == 16'h0000) else $error("upper bits set");
  keep_evt_a: assert property (rd_hit[0] && i_events[0] ##1
    !i_events[0] ##1 rd_hit[0] |=> o_hrdata == 32'h1)
    else $error("event lost at clear");
  no_wait_a: assert property (o_hreadyout)
    else $error("wait state inserted");
  resp_okay_a: assert property (!o_hresp)
    else $error("error response given");
  cover property (rd_hit[0] && i_events[0]);
  cover property (o_hrdata == 32'h0000FFFF);
  cover property (o_irq);
endmodule
bind pecnt_top pecnt_monitor i_mon (.i_sys_clk, .i_rst_n, .i_events,
  .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hready, .o_hrdata,
  .o_hreadyout, .o_hresp, .o_irq);

// ===== test/pecnt_host.sv
// Bus master model standing in for the management host.
`timescale 1ns/100ps
module pecnt_host (
  // Clock and answer.
  input wire logic i_sys_clk,
  input wire logic i_hready,
  input wire logic [31:0] i_hrdata,
  // Request.
  output logic o_hsel,
  output pecnt_pkg::pecnt_ahb_addr_s o_addr,
  output logic [31:0] o_hwdata
);
  initial begin
    o_hsel = 1'b0;
    o_addr = '0;
    o_hwdata = 32'h0;
  end
  // Call right after a rising edge; returns right after one.
  task automatic xfer(input logic w, input logic [31:0] a, d,
                      output logic [31:0] q);
    o_hsel <= 1'b1;
    o_addr <= '{2'b10, a, w, 3'b010};
    do @(posedge i_sys_clk); while (!i_hready);
    o_addr.htrans <= 2'b00;
    o_hwdata <= d;
    do @(posedge i_sys_clk); while (!i_hready);
    q = i_hrdata;
    // Stale write data is inverted so it is never mistaken for fresh.
    o_hwdata <= ~d;
  endtask
endmodule

// ===== test/tb_pecnt_top.sv
// Self-checking bench for the PHY event counters.
`timescale 1ns/100ps
`include "pecnt_cfg.svh"
module tb_pecnt_top;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  pecnt_pkg::pecnt_events_s ev = '0;
  pecnt_pkg::pecnt_ahb_addr_s ap;
  logic hsel, hready, hresp, irq;
  logic [31:0] wd, rdat, q;
  int n_errors = 0, checks = 0, cyc = 0;
  always #2 i_sys_clk = ~i_sys_clk;
  pecnt_host i_host (.i_sys_clk, .i_hready(hready), .i_hrdata(rdat),
    .o_hsel(hsel), .o_addr(ap), .o_hwdata(wd));
  pecnt_top i_dut (.i_sys_clk, .i_rst_n, .i_events(ev), .i_hsel(hsel),
    .i_haddr(ap.haddr), .i_htrans(ap.htrans), .i_hwrite(ap.hwrite),
    .i_hsize(ap.hsize), .i_hready(hready), .i_hwdata(wd), .o_hrdata(rdat),
    .o_hreadyout(hready), .o_hresp(hresp), .o_irq(irq));
  function automatic logic [31:0] ca(input int k);
    return 32'(4 * (`PECNT_IDX_FALSE_CARRIER + k));
  endfunction
  task chk(input string nm, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task pulse(input int k);
    ev <= pecnt_pkg::pecnt_events_s'(7'h01 << k);
    @(posedge i_sys_clk);
    ev <= '0;
    @(posedge i_sys_clk);
  endtask
  task t_reset;
    for (int k = 0; k < 7; k++) begin
      i_host.xfer(1'b0, ca(k), 32'h0, q);
      chk("reset count", q, 32'h0);
    end
    i_host.xfer(1'b1, ca(3), 32'h0000FFFF, q);
    i_host.xfer(1'b0, ca(3), 32'h0, q);
    chk("written count", q, 32'h0);
    i_host.xfer(1'b0, 32'h0000007C, 32'h0, q);
    chk("unmapped", q, 32'h0);
    chk("okay response", 32'(hresp), 32'h0);
  endtask
  task t_count;
    for (int k = 0; k < 7; k++) begin
      repeat (k + 1) pulse(k);
      i_host.xfer(1'b0, ca(k), 32'h0, q);
      chk("count", q, 32'(k + 1));
      i_host.xfer(1'b0, ca(k), 32'h0, q);
      chk("cleared", q, 32'h0);
    end
  endtask
  task t_sat;
    i_host.xfer(1'b1, 32'(4 * `PECNT_IDX_IRQ_ENABLE), 32'h7F, q);
    ev <= pecnt_pkg::pecnt_events_s'(7'h7F);
    repeat (65537) @(posedge i_sys_clk);
    ev <= '0;
    repeat (3) @(posedge i_sys_clk);
    chk("irq raised", 32'(irq), 32'h1);
    i_host.xfer(1'b0, 32'(4 * `PECNT_IDX_IRQ_STATUS), 32'h0, q);
    chk("dropped events", q, 32'h7F);
    i_host.xfer(1'b1, 32'(4 * `PECNT_IDX_IRQ_ENABLE), 32'h0, q);
    repeat (2) @(posedge i_sys_clk);
    chk("irq masked", 32'(irq), 32'h0);
    i_host.xfer(1'b1, 32'(4 * `PECNT_IDX_IRQ_CLEAR), 32'h7F, q);
    i_host.xfer(1'b0, 32'(4 * `PECNT_IDX_IRQ_STATUS), 32'h0, q);
    chk("status cleared", q, 32'h0);
    for (int k = 0; k < 7; k++) begin
      i_host.xfer(1'b0, ca(k), 32'h0, q);
      chk("saturated", q, 32'h0000FFFF);
    end
  endtask
  task t_race;
    for (int k = 0; k < 7; k++) begin
      fork
        i_host.xfer(1'b0, ca(k), 32'h0, q);
        pulse(k);
      join
      i_host.xfer(1'b0, ca(k), 32'h0, q);
      chk("kept event", q, 32'h1);
    end
  endtask
  task summarize;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 80000) begin
      n_errors++;
      summarize;
    end
  end
  initial begin
    repeat (2) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    @(posedge i_sys_clk);
    t_reset;
    t_count;
    t_sat;
    t_race;
    summarize;
  end
endmodule
